// file: hw/crc_gen.sv
// programmable crc generator with word fifo and axi4-lite register slave
//
// Summary of operation
// R1 - software sets length field and tap bits
// R2 - constant and top terms always included
// R3 - length 1111, taps 12,5 gives ccitt-16
// R4 - shifting starts only after go written one
// R5 - fifo depth 8 above length 7, else 16
// R6 - software writes bytes, low length+1 bits used
// R7 - count increments on write reaching top bit
// R8 - shift while go and count nonzero
// R9 - one bit per clock, length+1 per word
// R10 - full at depth, empty at zero
// R11 - software primes fifo then polls count
// R12 - software drains by running until empty
// R13 - software reads result after empty
// R14 - write when full wraps count, no interrupt
// R15 - software waits a cycle before reading count
// R16 - interrupt when count falls one to zero
// R17 - clearing go still drains fifo first
// R18 - sleep freezes state until clock returns
// R19 - feedback is data xor top bit into taps
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crc_gen_defines.svh"
module crc_gen
  import crc_gen_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        idle_req,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  // write channel capture
  logic        aw_held;
  logic [11:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  logic wr_known;
  logic wr_ctrl;
  logic wr_tap;
  logic wr_wdata;
  logic wr_mask;

  assign wr_ctrl  = wr_fire && aw_addr == `CTRL_OFFSET;
  assign wr_tap   = wr_fire && aw_addr == `TAP_OFFSET;
  assign wr_wdata = wr_fire && aw_addr == `WDATA_OFFSET;
  assign wr_mask  = wr_fire && aw_addr == `IRQ_MASK_OFFSET;
  assign wr_known = wr_ctrl || wr_tap || wr_wdata || wr_mask
                    || aw_addr == `IRQ_STAT_OFFSET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control state
  poly_cfg_type  cfg;
  logic          go;
  logic          idle_stop_bit;
  logic [15:0]   mask;
  logic [15:0]   stat;
  logic [4:0]    count;
  logic          idle_s1;
  logic          idle_s2;
  logic          frozen;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
    end else begin
      idle_s1 <= idle_req;
      idle_s2 <= idle_s1;
    end
  end

  // idle with stop set gates the engine exactly as sleep would
  assign frozen = idle_s2 && idle_stop_bit; // R18

  // one process owns the whole cfg struct so it has a single driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.len       <= 4'(`CTRL_RESET);
      cfg.taps      <= 15'(`TAP_RESET >> 1);
      go            <= 1'b0;
      idle_stop_bit <= 1'b0;
    end else begin
      if (wr_ctrl && w_strb[0]) begin
        cfg.len <= w_data[`CTRL_LEN_LSB +: 4]; // R1
        go      <= w_data[`CTRL_GO_BIT]; // R4
      end
      if (wr_ctrl && w_strb[1])
        idle_stop_bit <= w_data[`CTRL_IDLE_BIT];
      if (wr_tap)
        cfg.taps <= {w_strb[1] ? w_data[15:8] : cfg.taps[15:8],
                     w_strb[0] ? w_data[7:1] : cfg.taps[7:1]}; // R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      mask <= 16'h0000;
    else if (wr_mask)
      mask <= w_data[15:0];
  end

  // fifo and engine
  logic [4:0]  depth;
  logic        full;
  logic        empty;
  logic        top_lane;
  logic        push;
  logic [15:0] push_word;
  logic [15:0] fifo_mem [`FIFO_ENTRIES];
  logic [3:0]  wr_ptr;
  logic [3:0]  rd_ptr;
  logic [3:0]  bit_idx;
  logic        word_done;
  logic        shifting;
  logic        running;
  logic [15:0] crc;
  logic [15:0] head;

  assign depth = (cfg.len >= `SHALLOW_LEN_MIN) ? `SHALLOW_DEPTH
                                                : `DEEP_DEPTH; // R5
  assign full  = count == depth; // R10
  assign empty = count == 5'h00; // R10
  // a word counts once the lane holding its top bit is written
  assign top_lane  = cfg.len[3] ? w_strb[1] : w_strb[0]; // R6
  assign push      = wr_wdata && top_lane && !frozen; // R7
  assign push_word = w_data[15:0];
  assign head      = fifo_mem[rd_ptr];
  // go low still lets the fifo run dry
  assign shifting  = !empty && !frozen && (go || running); // R8 R17
  assign word_done = shifting && bit_idx == cfg.len; // R9

  // running outlives go, so a cleared go still empties the whole fifo
  always_ff @(posedge aclk) begin
    if (!aresetn)
      running <= 1'b0;
    else if (go)
      running <= 1'b1; // R4
    else if (empty)
      running <= 1'b0; // R17
  end

  eng_state_type state;
  assign state = shifting ? eng_shift : eng_idle;

  always_ff @(posedge aclk) begin
    if (push)
      fifo_mem[wr_ptr] <= push_word;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else begin
      if (push)
        wr_ptr <= (full || wr_ptr + 4'h1 == depth[3:0] && !depth[4])
                  ? 4'h0 : wr_ptr + 4'h1;
      if (push && full)
        rd_ptr <= 4'h0; // R14
      else if (word_done)
        rd_ptr <= (rd_ptr + 4'h1 == depth[3:0] && !depth[4])
                  ? 4'h0 : rd_ptr + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      count <= 5'h00;
    else if (push && full)
      count <= 5'h00; // R14
    else if (push && !word_done)
      count <= count + 5'h01; // R7
    else if (word_done && !push)
      count <= count - 5'h01; // R8
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (push && full))
      bit_idx <= 4'h0;
    else if (word_done)
      bit_idx <= 4'h0;
    else if (shifting)
      bit_idx <= bit_idx + 4'h1; // R9
  end

  // msb of each word goes in first
  logic data_bit;
  assign data_bit = head[cfg.len - bit_idx];

  crc_lfsr u_lfsr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cfg      (cfg),
    .shift_en (state == eng_shift),
    .data_bit (data_bit),
    .clear    (1'b0),
    .crc      (crc)
  );

  // interrupt: the wrap to zero is not a drain, so it never fires
  logic fire_event;
  assign fire_event = word_done && count == 5'h01 && !push; // R16 R14

  logic rd_fire;
  logic stat_read;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign stat_read = rd_fire && s_axi_araddr == `IRQ_STAT_OFFSET;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      stat <= 16'h0000;
    else
      stat <= {stat[15:1] & {15{!stat_read}}, fire_event | (stat[0] & !stat_read)};
  end

  assign irq = |(stat & mask);

  // read channel
  logic [15:0] ctrl_view;
  logic [31:0] rd_mux;
  logic        rd_known;

  assign ctrl_view = {2'b00, idle_stop_bit, count, full, empty, 1'b0, go,
                      cfg.len};
  assign rd_known  = s_axi_araddr == `CTRL_OFFSET
                  || s_axi_araddr == `TAP_OFFSET
                  || s_axi_araddr == `WDATA_OFFSET
                  || s_axi_araddr == `IRQ_STAT_OFFSET
                  || s_axi_araddr == `IRQ_MASK_OFFSET;
  assign rd_mux = (s_axi_araddr == `CTRL_OFFSET)  ? {16'h0000, ctrl_view} :
                  (s_axi_araddr == `TAP_OFFSET)   ? {16'h0000, cfg.taps, 1'b0} :
                  (s_axi_araddr == `WDATA_OFFSET) ? {16'h0000, crc} : // R13
                  (s_axi_araddr == `IRQ_STAT_OFFSET) ? {16'h0000, stat} :
                  (s_axi_araddr == `IRQ_MASK_OFFSET) ? {16'h0000, mask} :
                  32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  sequence last_bit_s;
    shifting && bit_idx == cfg.len && !push;
  endsequence

  no_go_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !go && !running |-> !shifting) // R4
    else $error("shifting started without go");

  depth_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    depth == (cfg.len > 4'h7 ? 5'h08 : 5'h10)) // R5
    else $error("fifo depth wrong for length");

  count_inc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    push && !full && !word_done |=> count == $past(count) + 5'h01) // R7
    else $error("count did not increment on push");

  count_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    last_bit_s |=> count == $past(count) - 5'h01) // R8
    else $error("count did not drop after last bit");

  bit_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shifting && bit_idx != cfg.len && !push |=> bit_idx == $past(bit_idx) + 4'h1) // R9
    else $error("bit index did not advance");

  flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_view[`CTRL_EMPTY_BIT] == (count == 5'h00)
    && ctrl_view[`CTRL_FULL_BIT] == (count == depth)) // R10
    else $error("full or empty flag wrong");

  wrap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    push && full |=> count == 5'h00 ##0 !stat[0] || $past(stat[0])) // R14
    else $error("full write did not wrap quietly");

  irq_one_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    last_bit_s and count == 5'h01 |=> stat[0]) // R16
    else $error("one to zero did not set status");

  drain_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_idx != 4'h0 && !empty && !frozen |-> shifting) // R17
    else $error("word abandoned mid shift");

  freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frozen |=> count == $past(count) || $past(push && full)) // R18
    else $error("state moved while frozen");

endmodule : crc_gen
`default_nettype wire

// file: hw/crc_gen_defines.svh
// register offsets, field positions, reset values and counts of the crc generator
`ifndef CRC_GEN_DEFINES_SVH
`define CRC_GEN_DEFINES_SVH

`define CTRL_OFFSET      12'h000
`define TAP_OFFSET       12'h004
`define WDATA_OFFSET     12'h008
`define IRQ_STAT_OFFSET  12'h00C
`define IRQ_MASK_OFFSET  12'h010

`define CTRL_LEN_LSB     0
`define CTRL_GO_BIT      4
`define CTRL_EMPTY_BIT   6
`define CTRL_FULL_BIT    7
`define CTRL_COUNT_LSB   8
`define CTRL_IDLE_BIT    13

`define CTRL_RESET       16'h0040
`define TAP_RESET        16'h0000
`define DEEP_DEPTH       5'h10
`define SHALLOW_DEPTH    5'h08
`define SHALLOW_LEN_MIN  4'h8
`define FIFO_ENTRIES     16

`endif

// file: hw/crc_gen_pkg.sv
// types shared by the crc generator files
package crc_gen_pkg;

  typedef struct packed {
    logic [3:0]  len;
    logic [15:1] taps;
  } poly_cfg_type;

  typedef enum logic [0:0] {
    eng_idle  = 1'b0,
    eng_shift = 1'b1
  } eng_state_type;

endpackage : crc_gen_pkg

// file: hw/crc_lfsr.sv
// bit-serial crc shift register with programmable length and taps
`timescale 1ns/1ps
`default_nettype none
module crc_lfsr
  import crc_gen_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire poly_cfg_type cfg,
  input  wire logic         shift_en,
  input  wire logic         data_bit,
  input  wire logic         clear,
  output logic [15:0]       crc
);

  logic        feedback;
  logic [15:0] next_crc;

  assign feedback = data_bit ^ crc[cfg.len]; // R19

  // stage 0 always takes the feedback; the constant term is implicit
  assign next_crc[0] = feedback; // R2
  genvar i;
  generate
    for (i = 1; i < 16; i = i + 1) begin : g_stage
      assign next_crc[i] = crc[i-1] ^ (cfg.taps[i] & feedback); // R19 R1
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn || clear)
      crc <= 16'h0000;
    else if (shift_en)
      crc <= next_crc; // R9
  end

  // for len 15 the top term is the feedback itself, no tap needed
  crc_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shift_en && !clear |=> crc[0] == $past(feedback))
    else $error("crc stage 0 did not take feedback"); // R3

endmodule : crc_lfsr
`default_nettype wire

// file: sim/tb_crc_gen.sv
// self-checking testbench for the programmable crc generator
`timescale 1ns/1ps
`default_nettype none
`include "crc_gen_defines.svh"
module tb_crc_gen;

  typedef struct packed {
    logic [1:0]  r;
    logic [31:0] d;
    logic [31:0] m;
  } note_type;

  logic        aclk;
  logic        aresetn;
  logic        idle_req;
  logic [11:0] awaddr;
  logic        awvalid;
  wire logic   awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  wire logic   wready;
  wire logic [1:0]  bresp;
  wire logic   bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  wire logic   arready;
  wire logic [31:0] rdata;
  wire logic [1:0]  rresp;
  wire logic   rvalid;
  logic        rready;
  wire logic   irq;
  note_type    notes[$];
  note_type    nt;
  int          n_mismatch;
  int          n_tests;
  logic [15:0] ref_crc;
  logic [31:0] d;
  logic [15:0] t;

  crc_gen i_crc_gen (
    .aclk(aclk), .aresetn(aresetn), .idle_req(idle_req),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic hang;
    n_mismatch++;
    wrap_up();
  endtask : hang

  // both channels offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dv,
                    input logic [3:0] s, input logic [1:0] er = 2'b00);
    int k;
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 100);
    if (k >= 100) hang();
    // bready stays high; a following write drives it high again at once
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff,
                    input logic [1:0] r = 2'b00);
    int k;
    notes.push_back(note_type'{r, e, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 100);
    if (k >= 100) hang();
  endtask : rd

  // read results are matched against the oldest note
  always @(posedge aclk) begin
    if (aresetn && rvalid && rready) begin
      if (notes.size() == 0) begin
        chk(32'h0000_0001, 32'h0000_0000);
      end else begin
        nt = notes.pop_front();
        chk(rdata & nt.m, nt.d & nt.m);
        chk({30'h0, rresp}, {30'h0, nt.r});
      end
    end
  end

  // msb first; data xor top bit fed into stage 0 and every tapped stage
  task automatic feed(input logic [31:0] dv, input int len,
                      input logic [15:0] tp);
    logic fb;
    for (int b = len; b >= 0; b--) begin
      fb = dv[b] ^ ref_crc[len];
      ref_crc = (ref_crc << 1) ^ ({tp[15:1], 1'b1} & {16{fb}});
    end
  endtask : feed

  task automatic rst;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    ref_crc = 16'h0000;
    @(posedge aclk);
  endtask : rst

  task automatic run_crc(input int len, input logic [15:0] tp, input int n,
                         input bit stop);
    logic [31:0] m;
    int          dep;
    m = 32'((33'h1 << (len + 1)) - 33'h1);
    dep = (len > 7) ? 8 : 16;
    wr(`CTRL_OFFSET, 32'(len), 4'b0001);
    wr(`TAP_OFFSET, {16'h0000, tp}, 4'b0011);
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      wr(`WDATA_OFFSET, d, (len > 7) ? 4'b0011 : 4'b0001);
      feed(d, len, tp);
    end
    rd(`CTRL_OFFSET, 32'((n << 8) | (n == dep ? 128 : 0) | len));
    wr(`CTRL_OFFSET, 32'(16 | len), 4'b0001);
    if (stop) wr(`CTRL_OFFSET, 32'(len), 4'b0001);
    repeat ((len + 1) * n + 8) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(`IRQ_STAT_OFFSET, 32'h1);
    rd(`CTRL_OFFSET, 32'(64 | (stop ? 0 : 16) | len));
    rd(`WDATA_OFFSET, {16'h0000, ref_crc}, m);
    rd(`IRQ_STAT_OFFSET, 32'h0);
  endtask : run_crc

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end

  initial begin
    {aresetn, idle_req, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(87));
    rst();
    rd(`CTRL_OFFSET, 32'h0000_0040);
    rd(`TAP_OFFSET, 32'h0000_0000);
    rd(`IRQ_STAT_OFFSET, 32'h0000_0000);
    rd(`IRQ_MASK_OFFSET, 32'h0000_0000);
    wr(`TAP_OFFSET, 32'hffff_ffff, 4'b1111);
    rd(`TAP_OFFSET, 32'h0000_fffe);
    wr(12'h020, 32'h0000_0000, 4'b1111, 2'b10);
    rd(12'h020, 32'h0000_0000, 32'h0000_0000, 2'b10);
    run_crc(15, 16'h1020, 3, 1'b0);
    run_crc(7, 16'($urandom), 16, 1'b1);
    for (int l = 0; l < 16; l++) begin
      run_crc(l, 16'($urandom), 2, 1'b0);
    end
    // overfill at length 8: depth is 8, the ninth word wraps the count
    for (int i = 0; i < 8; i++) begin
      wr(`CTRL_OFFSET, 32'h0000_0008, 4'b0001);
      wr(`WDATA_OFFSET, $urandom, 4'b0011);
    end
    rd(`CTRL_OFFSET, 32'h0000_0888);
    wr(`WDATA_OFFSET, $urandom, 4'b0011);
    rd(`CTRL_OFFSET, 32'h0000_0048);
    rd(`IRQ_STAT_OFFSET, 32'h0000_0000);
    // stop in idle freezes the shifter until the request goes away
    t = 16'h0006;
    wr(`IRQ_MASK_OFFSET, 32'h0000_0001, 4'b0001);
    wr(`CTRL_OFFSET, 32'h0000_2003, 4'b0011);
    wr(`TAP_OFFSET, {16'h0000, t}, 4'b0011);
    d = $urandom;
    wr(`WDATA_OFFSET, d, 4'b0001);
    feed(d, 3, t);
    idle_req <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(`CTRL_OFFSET, 32'h0000_2013, 4'b0011);
    repeat (20) @(posedge aclk);
    rd(`CTRL_OFFSET, 32'h0000_2113);
    chk({31'h0, irq}, 32'h0);
    idle_req <= 1'b0;
    repeat (14) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(`IRQ_STAT_OFFSET, 32'h0000_0001);
    rd(`WDATA_OFFSET, {16'h0000, ref_crc}, 32'h0000_000f);
    chk({31'h0, irq}, 32'h0);
    repeat (4) @(posedge aclk);
    chk(32'(notes.size()), 32'h0);
    wrap_up();
  end

endmodule : tb_crc_gen
`default_nettype wire
